// ===== logic/rsawr_pkg.sv
// constants for the reader status, wave shaping and wake-up register bank
// assumes a plain register port; two register spaces picked by a space bit
// Behaviour
// - regulator readback upper nibble: last adjust code
// - readback bit 0 shows current limit
// - rssi display: am high, pm low
// - peaks held until reception start or clear
// - gain cut display: am high, pm low
// - rx-only supply bit selects driver return
// - tx on/off shaping bit enables shaped switching
// - symmetry bit selects symmetrical shape
// - sink bit selects strong or weak sink
// - four-bit reference filter constant
// - status bit 7 channel, bit 6 field
// - status bit 5 tx, excluding auto avoidance
// - status bits 4..2 oscillator and receiver
// - status bits 1..0 detector modes
// - overshoot cells with two-bit drive level
// - shaped mode: cell bit picks supply
// - undershoot cells after modulation, same encoding
// - timer range bit and three-bit timeout
// - timeout is (code+1) times base
// - timeout interrupt on every expiry
// - amplitude measurement and wake interrupt
// - phase measurement and wake interrupt
package rsawr_pkg;
  localparam logic [5:0] ADDR_REG_READBACK = 6'h2C;
  localparam logic [5:0] ADDR_RSSI = 6'h2D;
  localparam logic [5:0] ADDR_GAIN = 6'h2E;
  localparam logic [5:0] ADDR_AUX = 6'h31;
  localparam logic [5:0] ADDR_WAKE = 6'h32;
  localparam logic [5:0] ADDR_SHAPE_ONE = 6'h2E;
  localparam logic [5:0] ADDR_SHAPE_TWO = 6'h2F;
  localparam logic [5:0] ADDR_OV_HIGH = 6'h30;
  localparam logic [5:0] ADDR_OV_LOW = 6'h31;
  localparam logic [5:0] ADDR_UN_HIGH = 6'h32;
  localparam logic [5:0] ADDR_UN_LOW = 6'h33;
  // address bit 6 selects space b
  localparam int SPACE_BIT = 6;
  localparam int ILIM_BIT = 0;
  localparam int CONT_BIT = 3;
  localparam int RXONLY_BIT = 1;
  localparam int TXONOFF_BIT = 0;
  localparam int SYM_BIT = 5;
  localparam int SINK_BIT = 4;
  localparam int RANGE_BIT = 7;
  localparam int WTO_BIT = 3;
  localparam int WAM_BIT = 2;
  localparam int WPH_BIT = 1;
  localparam logic [7:0] SHAPE_ONE_MASK = 8'h0B;
  localparam logic [7:0] SHAPE_TWO_MASK = 8'h3F;
  localparam logic [7:0] WAKE_MASK = 8'hFE;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [1:0] LEVEL_DRIVE = 2'h0;
  localparam logic [1:0] LEVEL_AM = 2'h1;
  localparam logic [1:0] LEVEL_STOP = 2'h2;
  localparam int CLK_HZ = 125000000;
  localparam int BASE_LONG_MS = 100;
  localparam int BASE_SHORT_MS = 10;
  localparam int BASE_LONG_CYC = CLK_HZ / 1000 * BASE_LONG_MS;
  localparam int BASE_SHORT_CYC = CLK_HZ / 1000 * BASE_SHORT_MS;
  typedef enum logic [1:0] {
    RSAWR_IDLE = 2'b00,
    RSAWR_MEAS = 2'b01,
    RSAWR_EVAL = 2'b10
  } rsawr_state_t;
endpackage

// ===== logic/rsawr_regs.sv
// register bank: regulator, rssi, gain, shaping, status and wake-up timer
// assumes inputs synchronous to I_CLK; measurement engine is outside
//
// Implementation choice: the address-and-strobe port.
module rsawr_regs #(
  parameter int BASE_LONG_CYC = rsawr_pkg::BASE_LONG_CYC,
  parameter int BASE_SHORT_CYC = rsawr_pkg::BASE_SHORT_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [6:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_ADJUST_DONE,
  input wire logic [3:0] I_ADJUST_CODE,
  input wire logic I_CURRENT_LIMIT,
  input wire logic [3:0] I_AMPLITUDE_LEVEL,
  input wire logic [3:0] I_PHASE_LEVEL,
  input wire logic I_RX_START,
  input wire logic I_CLEAR_RSSI,
  input wire logic [3:0] I_AMPLITUDE_GAIN_CUT,
  input wire logic [3:0] I_PHASE_GAIN_CUT,
  input wire logic I_RX_CHANNEL_PM,
  input wire logic I_FIELD_DETECTED,
  input wire logic I_TX_ACTIVE,
  input wire logic I_TX_AUTO_AVOID,
  input wire logic I_OSC_STABLE,
  input wire logic I_RX_ENABLED,
  input wire logic I_RX_RECEIVING,
  input wire logic I_PEER_DETECT,
  input wire logic I_COLLISION_AVOID_ACTIVE,
  input wire logic I_SHAPED_MODULATION_MODE,
  input wire logic I_MEAS_DONE,
  input wire logic [7:0] I_AMPLITUDE_RESULT,
  input wire logic [7:0] I_PHASE_RESULT,
  input wire logic [7:0] I_AMPLITUDE_REF,
  input wire logic [7:0] I_PHASE_REF,
  input wire logic [3:0] I_AMPLITUDE_DELTA,
  input wire logic [3:0] I_PHASE_DELTA,
  output logic O_REGULATOR_CONTINUOUS,
  output logic O_RX_ONLY_SUPPLY,
  output logic O_TXONOFF_SHAPING,
  output logic O_SHAPE_SYMMETRY,
  output logic O_STRONG_SINK,
  output logic [3:0] O_REFERENCE_FILTER_CONSTANT,
  output logic [13:0] O_OVERSHOOT_CELLS,
  output logic [1:0] O_OVERSHOOT_DRIVE_LEVEL,
  output logic [13:0] O_UNDERSHOOT_CELLS,
  output logic [1:0] O_UNDERSHOOT_DRIVE_LEVEL,
  output logic O_OVERSHOOT_AM_MASK_VALID,
  output logic O_MEASURE_AMPLITUDE,
  output logic O_MEASURE_PHASE,
  output logic O_IRQ_TIMEOUT,
  output logic O_IRQ_AMPLITUDE_WAKE,
  output logic O_IRQ_PHASE_WAKE
);

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  logic [3:0] regulator_code;
  logic [3:0] amplitude_channel_peak;
  logic [3:0] phase_channel_peak;
  logic [7:0] shape_one;
  logic [7:0] shape_two;
  logic [7:0] ov_high;
  logic [7:0] ov_low;
  logic [7:0] un_high;
  logic [7:0] un_low;
  logic [7:0] wake_ctrl;
  logic space_b;
  logic [5:0] reg_addr;

  assign space_b = I_ADDR[rsawr_pkg::SPACE_BIT];
  assign reg_addr = I_ADDR[5:0];

  function automatic logic hit(input logic [5:0] a, input logic sp, input logic [5:0] o,
                               input logic want_b);
    hit = (a == o) && (sp == want_b);
  endfunction

  // only read-write space b and wake control are writable; displays ignore writes
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      shape_one <= rsawr_pkg::RESET_ZERO;
      shape_two <= rsawr_pkg::RESET_ZERO;
      ov_high <= rsawr_pkg::RESET_ZERO;
      ov_low <= rsawr_pkg::RESET_ZERO;
      un_high <= rsawr_pkg::RESET_ZERO;
      un_low <= rsawr_pkg::RESET_ZERO;
      wake_ctrl <= rsawr_pkg::RESET_ZERO;
    end else if (I_WR) begin
      if (hit(reg_addr, space_b, rsawr_pkg::ADDR_SHAPE_ONE, 1'b1)) begin
        shape_one <= I_WDATA & rsawr_pkg::SHAPE_ONE_MASK;
      end
      if (hit(reg_addr, space_b, rsawr_pkg::ADDR_SHAPE_TWO, 1'b1)) begin
        shape_two <= I_WDATA & rsawr_pkg::SHAPE_TWO_MASK;
      end
      if (hit(reg_addr, space_b, rsawr_pkg::ADDR_OV_HIGH, 1'b1)) begin
        ov_high <= I_WDATA;
      end
      if (hit(reg_addr, space_b, rsawr_pkg::ADDR_OV_LOW, 1'b1)) begin
        ov_low <= I_WDATA;
      end
      if (hit(reg_addr, space_b, rsawr_pkg::ADDR_UN_HIGH, 1'b1)) begin
        un_high <= I_WDATA;
      end
      if (hit(reg_addr, space_b, rsawr_pkg::ADDR_UN_LOW, 1'b1)) begin
        un_low <= I_WDATA;
      end
      if (hit(reg_addr, space_b, rsawr_pkg::ADDR_WAKE, 1'b0)) begin
        wake_ctrl <= I_WDATA & rsawr_pkg::WAKE_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // captured display state

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      regulator_code <= 4'h0;
    end else if (I_ADJUST_DONE) begin
      regulator_code <= I_ADJUST_CODE;
    end
  end

  // a new sample in the clearing cycle still counts: capture beats clear
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      amplitude_channel_peak <= 4'h0;
      phase_channel_peak <= 4'h0;
    end else if (I_RX_START || I_CLEAR_RSSI) begin
      amplitude_channel_peak <= I_AMPLITUDE_LEVEL;
      phase_channel_peak <= I_PHASE_LEVEL;
    end else begin
      if (I_AMPLITUDE_LEVEL > amplitude_channel_peak) begin
        amplitude_channel_peak <= I_AMPLITUDE_LEVEL;
      end
      if (I_PHASE_LEVEL > phase_channel_peak) begin
        phase_channel_peak <= I_PHASE_LEVEL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  logic [7:0] next_rdata;
  logic [7:0] aux_status;

  assign aux_status = {I_RX_CHANNEL_PM, I_FIELD_DETECTED,
                       I_TX_ACTIVE & ~I_TX_AUTO_AVOID,
                       I_OSC_STABLE, I_RX_ENABLED, I_RX_RECEIVING,
                       I_PEER_DETECT, I_COLLISION_AVOID_ACTIVE};

  always_comb begin
    next_rdata = 8'h00;
    if (!space_b) begin
      unique case (reg_addr)
        rsawr_pkg::ADDR_RSSI: next_rdata = {amplitude_channel_peak, phase_channel_peak};
        rsawr_pkg::ADDR_GAIN: next_rdata = {I_AMPLITUDE_GAIN_CUT, I_PHASE_GAIN_CUT};
        rsawr_pkg::ADDR_AUX: next_rdata = aux_status;
        rsawr_pkg::ADDR_WAKE: next_rdata = wake_ctrl;
        default: next_rdata = 8'h00;
      endcase
    end else begin
      unique case (reg_addr)
        rsawr_pkg::ADDR_REG_READBACK: next_rdata = {regulator_code, 3'h0, I_CURRENT_LIMIT};
        rsawr_pkg::ADDR_SHAPE_ONE: next_rdata = shape_one;
        rsawr_pkg::ADDR_SHAPE_TWO: next_rdata = shape_two;
        rsawr_pkg::ADDR_OV_HIGH: next_rdata = ov_high;
        rsawr_pkg::ADDR_OV_LOW: next_rdata = ov_low;
        rsawr_pkg::ADDR_UN_HIGH: next_rdata = un_high;
        rsawr_pkg::ADDR_UN_LOW: next_rdata = un_low;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      O_RDATA <= next_rdata;
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shaping and drive outputs

  logic shaped;
  assign shaped = I_SHAPED_MODULATION_MODE;

  // shaping settings drive nothing unless shaped mode is on
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_REGULATOR_CONTINUOUS <= 1'b0;
      O_RX_ONLY_SUPPLY <= 1'b0;
      O_TXONOFF_SHAPING <= 1'b0;
      O_SHAPE_SYMMETRY <= 1'b0;
      O_STRONG_SINK <= 1'b0;
      O_REFERENCE_FILTER_CONSTANT <= 4'h0;
    end else begin
      O_REGULATOR_CONTINUOUS <= shaped & shape_one[rsawr_pkg::CONT_BIT];
      O_RX_ONLY_SUPPLY <= shaped & shape_one[rsawr_pkg::RXONLY_BIT];
      O_TXONOFF_SHAPING <= shaped & shape_one[rsawr_pkg::TXONOFF_BIT];
      O_SHAPE_SYMMETRY <= shaped & shape_two[rsawr_pkg::SYM_BIT];
      O_STRONG_SINK <= shaped & shape_two[rsawr_pkg::SINK_BIT];
      O_REFERENCE_FILTER_CONSTANT <= shaped ? shape_two[3:0] : 4'h0;
    end
  end

  // in shaped mode the level selects are forced to LEVEL_DRIVE; cell bit picks supply directly
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_OVERSHOOT_CELLS <= 14'h0000;
      O_UNDERSHOOT_CELLS <= 14'h0000;
      O_OVERSHOOT_DRIVE_LEVEL <= rsawr_pkg::LEVEL_DRIVE;
      O_UNDERSHOOT_DRIVE_LEVEL <= rsawr_pkg::LEVEL_DRIVE;
      O_OVERSHOOT_AM_MASK_VALID <= 1'b0;
    end else begin
      O_OVERSHOOT_CELLS <= {ov_high[5:0], ov_low};
      O_UNDERSHOOT_CELLS <= {un_high[5:0], un_low};
      O_OVERSHOOT_DRIVE_LEVEL <= shaped ? rsawr_pkg::LEVEL_DRIVE : ov_high[7:6];
      O_UNDERSHOOT_DRIVE_LEVEL <= shaped ? rsawr_pkg::LEVEL_DRIVE : un_high[7:6];
      O_OVERSHOOT_AM_MASK_VALID <= shaped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake-up timer

  logic [31:0] base_cnt;
  logic [2:0] step_cnt;
  logic base_tick;
  logic expiry;
  logic [31:0] base_len;

  assign base_len = wake_ctrl[rsawr_pkg::RANGE_BIT] ? 32'(BASE_SHORT_CYC) :
                                                      32'(BASE_LONG_CYC);
  assign base_tick = (base_cnt >= base_len - 32'h1);
  assign expiry = base_tick && (step_cnt >= wake_ctrl[6:4]);

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      base_cnt <= 32'h0;
      step_cnt <= 3'h0;
    end else if (base_tick) begin
      base_cnt <= 32'h0;
      step_cnt <= expiry ? 3'h0 : step_cnt + 3'h1;
    end else begin
      base_cnt <= base_cnt + 32'h1;
    end
  end

  function automatic logic over_delta(input logic [7:0] v, input logic [7:0] r,
                                      input logic [3:0] d);
    logic [7:0] diff;
    diff = (v > r) ? v - r : r - v;
    over_delta = diff > {4'h0, d};
  endfunction

  rsawr_pkg::rsawr_state_t state;
  logic want_amp;
  logic want_phase;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state <= rsawr_pkg::RSAWR_IDLE;
      want_amp <= 1'b0;
      want_phase <= 1'b0;
    end else begin
      unique case (state)
        rsawr_pkg::RSAWR_IDLE: begin
          if (expiry && (wake_ctrl[rsawr_pkg::WAM_BIT] || wake_ctrl[rsawr_pkg::WPH_BIT])) begin
            want_amp <= wake_ctrl[rsawr_pkg::WAM_BIT];
            want_phase <= wake_ctrl[rsawr_pkg::WPH_BIT];
            state <= rsawr_pkg::RSAWR_MEAS;
          end
        end
        rsawr_pkg::RSAWR_MEAS: begin
          if (I_MEAS_DONE) begin
            state <= rsawr_pkg::RSAWR_EVAL;
          end
        end
        rsawr_pkg::RSAWR_EVAL: state <= rsawr_pkg::RSAWR_IDLE;
        default: state <= rsawr_pkg::RSAWR_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_MEASURE_AMPLITUDE <= 1'b0;
      O_MEASURE_PHASE <= 1'b0;
      O_IRQ_TIMEOUT <= 1'b0;
      O_IRQ_AMPLITUDE_WAKE <= 1'b0;
      O_IRQ_PHASE_WAKE <= 1'b0;
    end else begin
      O_MEASURE_AMPLITUDE <= expiry && wake_ctrl[rsawr_pkg::WAM_BIT] &&
                             state == rsawr_pkg::RSAWR_IDLE;
      O_MEASURE_PHASE <= expiry && wake_ctrl[rsawr_pkg::WPH_BIT] &&
                         state == rsawr_pkg::RSAWR_IDLE;
      O_IRQ_TIMEOUT <= expiry && wake_ctrl[rsawr_pkg::WTO_BIT];
      O_IRQ_AMPLITUDE_WAKE <= state == rsawr_pkg::RSAWR_EVAL && want_amp &&
          over_delta(I_AMPLITUDE_RESULT, I_AMPLITUDE_REF, I_AMPLITUDE_DELTA);
      O_IRQ_PHASE_WAKE <= state == rsawr_pkg::RSAWR_EVAL && want_phase &&
          over_delta(I_PHASE_RESULT, I_PHASE_REF, I_PHASE_DELTA);
    end
  end

endmodule // rsawr_regs

// ===== test/rsawr_regs_monitor.sv
// checker for the status, shaping and wake-up register bank
// bound to rsawr_regs from the bench top; sees only its ports
module rsawr_regs_monitor #(
  parameter int BASE_LONG_CYC = 20,
  parameter int BASE_SHORT_CYC = 5
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [6:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic I_CURRENT_LIMIT,
  input wire logic [3:0] I_AMPLITUDE_GAIN_CUT,
  input wire logic [3:0] I_PHASE_GAIN_CUT,
  input wire logic I_RX_CHANNEL_PM,
  input wire logic I_FIELD_DETECTED,
  input wire logic I_TX_ACTIVE,
  input wire logic I_TX_AUTO_AVOID,
  input wire logic I_OSC_STABLE,
  input wire logic I_RX_ENABLED,
  input wire logic I_RX_RECEIVING,
  input wire logic I_PEER_DETECT,
  input wire logic I_COLLISION_AVOID_ACTIVE,
  input wire logic I_MEAS_DONE,
  input wire logic O_REGULATOR_CONTINUOUS,
  input wire logic O_RX_ONLY_SUPPLY,
  input wire logic O_TXONOFF_SHAPING,
  input wire logic O_SHAPE_SYMMETRY,
  input wire logic O_STRONG_SINK,
  input wire logic [3:0] O_REFERENCE_FILTER_CONSTANT,
  input wire logic [13:0] O_UNDERSHOOT_CELLS,
  input wire logic [1:0] O_OVERSHOOT_DRIVE_LEVEL,
  input wire logic [1:0] O_UNDERSHOOT_DRIVE_LEVEL,
  input wire logic O_OVERSHOOT_AM_MASK_VALID,
  input wire logic O_IRQ_TIMEOUT,
  input wire logic O_IRQ_AMPLITUDE_WAKE,
  input wire logic O_IRQ_PHASE_WAKE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  ////////////////////////////////////////////////////////////////////////////////
  sequence gain_rd; I_RD && I_ADDR == 7'h2E; endsequence
  sequence aux_rd; I_RD && I_ADDR == 7'h31; endsequence
  sequence back_rd; I_RD && I_ADDR == 7'h6C; endsequence
  sequence under_wr; I_WR && I_ADDR == 7'h72; endsequence
  ////////////////////////////////////////////////////////////////////////////////
  gain_read_a: assert property (gain_rd |=> O_RDATA == $past({I_AMPLITUDE_GAIN_CUT,
    I_PHASE_GAIN_CUT})) else $error("gain read mismatch");
  aux_read_a: assert property (aux_rd |=> O_RDATA == $past({I_RX_CHANNEL_PM,
    I_FIELD_DETECTED, I_TX_ACTIVE & ~I_TX_AUTO_AVOID, I_OSC_STABLE, I_RX_ENABLED,
    I_RX_RECEIVING, I_PEER_DETECT, I_COLLISION_AVOID_ACTIVE})) else $error("aux read mismatch");
  limit_bit_a: assert property (back_rd |=> O_RDATA[3:0] == {3'h0, $past(I_CURRENT_LIMIT)})
    else $error("current limit bit mismatch");
  under_cells_a: assert property (under_wr |=> ##1 O_UNDERSHOOT_CELLS[13:8] ==
    $past(I_WDATA[5:0], 2))
    else $error("undershoot cells not written");
  shaped_levels_a: assert property (O_OVERSHOOT_AM_MASK_VALID |->
    {O_OVERSHOOT_DRIVE_LEVEL, O_UNDERSHOOT_DRIVE_LEVEL} == 4'h0) else $error("levels in shaped mode");
  inert_config_a: assert property (!O_OVERSHOOT_AM_MASK_VALID |-> {O_REGULATOR_CONTINUOUS,
    O_RX_ONLY_SUPPLY, O_TXONOFF_SHAPING, O_SHAPE_SYMMETRY, O_STRONG_SINK,
    O_REFERENCE_FILTER_CONSTANT} == 9'h000) else $error("shaping config active");
  timeout_gap_a: assert property (O_IRQ_TIMEOUT |=> !O_IRQ_TIMEOUT [*4])
    else $error("timeout pulses too close");
  amp_wake_a: assert property (O_IRQ_AMPLITUDE_WAKE |-> $past(I_MEAS_DONE, 2))
    else $error("amplitude wake without measurement");
  phase_wake_a: assert property (O_IRQ_PHASE_WAKE |-> $past(I_MEAS_DONE, 2))
    else $error("phase wake without measurement");
endmodule // rsawr_regs_monitor

// ===== test/tb_rsawr_regs.sv
// self-checking bench for the register bank
// drives every port itself; short wake-up bases keep the run brief
module tb_rsawr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LONG = 20;
  localparam int SHORT = 5;
  localparam logic [22:0] ROWS [8] = '{{7'h6E, 8'hFF, 8'h0B}, {7'h6F, 8'hFF, 8'h3F},
    {7'h70, 8'hA5, 8'hA5}, {7'h71, 8'h5A, 8'h5A}, {7'h72, 8'hC3, 8'hC3},
    {7'h73, 8'h3C, 8'h3C}, {7'h32, 8'h01, 8'h00}, {7'h7F, 8'hFF, 8'h00}};
  localparam logic [8:0] AUXP [4] = '{9'h1FF, 9'h040, 9'h155, 9'h0AA};
  localparam logic [7:0] WCFG [4] = '{8'h78, 8'h88, 8'hB8, 8'h9E};
  logic I_CLK, I_RST, I_WR, I_RD, I_ADJUST_DONE, I_CURRENT_LIMIT, I_RX_START, I_CLEAR_RSSI;
  logic I_RX_CHANNEL_PM, I_FIELD_DETECTED, I_TX_ACTIVE, I_TX_AUTO_AVOID, I_OSC_STABLE;
  logic I_RX_ENABLED, I_RX_RECEIVING, I_PEER_DETECT, I_COLLISION_AVOID_ACTIVE;
  logic I_SHAPED_MODULATION_MODE, I_MEAS_DONE, O_REGULATOR_CONTINUOUS, O_RX_ONLY_SUPPLY;
  logic O_TXONOFF_SHAPING, O_SHAPE_SYMMETRY, O_STRONG_SINK, O_OVERSHOOT_AM_MASK_VALID;
  logic O_MEASURE_AMPLITUDE, O_MEASURE_PHASE, O_IRQ_TIMEOUT, O_IRQ_AMPLITUDE_WAKE;
  logic O_IRQ_PHASE_WAKE;
  logic [6:0] I_ADDR;
  logic [7:0] I_WDATA, O_RDATA, I_AMPLITUDE_RESULT, I_PHASE_RESULT, I_AMPLITUDE_REF, I_PHASE_REF;
  logic [3:0] I_ADJUST_CODE, I_AMPLITUDE_LEVEL, I_PHASE_LEVEL, I_AMPLITUDE_GAIN_CUT;
  logic [3:0] I_PHASE_GAIN_CUT, I_AMPLITUDE_DELTA, I_PHASE_DELTA, O_REFERENCE_FILTER_CONSTANT;
  logic [13:0] O_OVERSHOOT_CELLS, O_UNDERSHOOT_CELLS;
  logic [1:0] O_OVERSHOOT_DRIVE_LEVEL, O_UNDERSHOOT_DRIVE_LEVEL;
  logic [8:0] aux_in;
  int failures = 0;
  int n_compared = 0;
  int n;
  assign {I_RX_CHANNEL_PM, I_FIELD_DETECTED, I_TX_ACTIVE, I_TX_AUTO_AVOID, I_OSC_STABLE,
    I_RX_ENABLED, I_RX_RECEIVING, I_PEER_DETECT, I_COLLISION_AVOID_ACTIVE} = aux_in;
  rsawr_regs #(.BASE_LONG_CYC(LONG), .BASE_SHORT_CYC(SHORT)) dut_u (.I_CLK, .I_RST, .I_ADDR,
    .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_ADJUST_DONE, .I_ADJUST_CODE, .I_CURRENT_LIMIT,
    .I_AMPLITUDE_LEVEL, .I_PHASE_LEVEL, .I_RX_START, .I_CLEAR_RSSI, .I_AMPLITUDE_GAIN_CUT,
    .I_PHASE_GAIN_CUT, .I_RX_CHANNEL_PM, .I_FIELD_DETECTED, .I_TX_ACTIVE, .I_TX_AUTO_AVOID,
    .I_OSC_STABLE, .I_RX_ENABLED, .I_RX_RECEIVING, .I_PEER_DETECT, .I_COLLISION_AVOID_ACTIVE,
    .I_SHAPED_MODULATION_MODE, .I_MEAS_DONE, .I_AMPLITUDE_RESULT, .I_PHASE_RESULT,
    .I_AMPLITUDE_REF, .I_PHASE_REF, .I_AMPLITUDE_DELTA, .I_PHASE_DELTA, .O_REGULATOR_CONTINUOUS,
    .O_RX_ONLY_SUPPLY, .O_TXONOFF_SHAPING, .O_SHAPE_SYMMETRY, .O_STRONG_SINK,
    .O_REFERENCE_FILTER_CONSTANT, .O_OVERSHOOT_CELLS, .O_OVERSHOOT_DRIVE_LEVEL,
    .O_UNDERSHOOT_CELLS, .O_UNDERSHOOT_DRIVE_LEVEL, .O_OVERSHOOT_AM_MASK_VALID,
    .O_MEASURE_AMPLITUDE, .O_MEASURE_PHASE, .O_IRQ_TIMEOUT, .O_IRQ_AMPLITUDE_WAKE,
    .O_IRQ_PHASE_WAKE);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    chk($sformatf("read %h", a), O_RDATA, e);
  endtask
  // bounded: a silent timer must not hang the run
  task automatic wait_tmo(output int k);
    k = 0;
    do begin
      @(posedge I_CLK);
      #1;
      k++;
    end while (O_IRQ_TIMEOUT !== 1'b1 && k < 400);
  endtask
  task automatic meas(input logic [7:0] ar, input logic [7:0] pr, input logic [1:0] e);
    logic [1:0] seen;
    int k;
    seen = 2'b00;
    @(posedge I_CLK);
    I_AMPLITUDE_RESULT <= ar;
    I_PHASE_RESULT <= pr;
    I_MEAS_DONE <= 1'b1;
    @(posedge I_CLK);
    I_MEAS_DONE <= 1'b0;
    repeat (4) begin
      @(posedge I_CLK);
      #1;
      seen = seen | {O_IRQ_AMPLITUDE_WAKE, O_IRQ_PHASE_WAKE};
    end
    chk("wake irq", seen, e);
    // next expiry finds the engine idle and launches a new measurement
    wait_tmo(k);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    I_CLK = 1'b0;
    forever #4 I_CLK = ~I_CLK;
  end
  initial begin
    repeat (20000) @(posedge I_CLK);
    failures++;
    give_verdict();
  end
  initial begin
    I_RST = 1'b1;
    {I_WR, I_RD, I_ADJUST_DONE, I_CURRENT_LIMIT, I_RX_START, I_CLEAR_RSSI} = '0;
    {I_SHAPED_MODULATION_MODE, I_MEAS_DONE, aux_in, I_ADDR, I_WDATA, I_ADJUST_CODE} = '0;
    {I_AMPLITUDE_LEVEL, I_PHASE_LEVEL, I_AMPLITUDE_GAIN_CUT, I_PHASE_GAIN_CUT} = '0;
    {I_AMPLITUDE_RESULT, I_PHASE_RESULT, I_AMPLITUDE_DELTA, I_PHASE_DELTA} = '0;
    I_AMPLITUDE_REF = 8'h40;
    I_PHASE_REF = 8'h30;
    repeat (12) @(posedge I_CLK);
    I_RST <= 1'b0;
    foreach (ROWS[i]) begin
      wr(ROWS[i][22:16], ROWS[i][15:8]);
      rc(ROWS[i][22:16], ROWS[i][7:0]);
    end
    @(posedge I_CLK);
    {I_AMPLITUDE_GAIN_CUT, I_PHASE_GAIN_CUT} <= 8'hC3;
    wr(7'h2E, 8'h00);
    rc(7'h2E, 8'hC3);
    #1;
    chk("cells off", {O_OVERSHOOT_CELLS, O_OVERSHOOT_DRIVE_LEVEL}, 16'h956A);
    chk("under off", {O_UNDERSHOOT_CELLS, O_UNDERSHOOT_DRIVE_LEVEL}, 16'h0CF3);
    @(posedge I_CLK) I_SHAPED_MODULATION_MODE <= 1'b1;
    repeat (2) @(posedge I_CLK);
    #1;
    chk("levels", {O_OVERSHOOT_DRIVE_LEVEL, O_UNDERSHOOT_DRIVE_LEVEL}, 16'h0000);
    chk("shape", {O_REGULATOR_CONTINUOUS, O_RX_ONLY_SUPPLY, O_TXONOFF_SHAPING, O_SHAPE_SYMMETRY,
      O_STRONG_SINK, O_REFERENCE_FILTER_CONSTANT}, 16'h01FF);
    wr(7'h6E, 8'h08);
    wr(7'h6F, 8'h0A);
    @(posedge I_CLK);
    #1;
    chk("shape", {O_REGULATOR_CONTINUOUS, O_RX_ONLY_SUPPLY, O_TXONOFF_SHAPING, O_SHAPE_SYMMETRY,
      O_STRONG_SINK, O_REFERENCE_FILTER_CONSTANT}, 16'h010A);
    @(posedge I_CLK);
    I_ADJUST_CODE <= 4'h9;
    I_ADJUST_DONE <= 1'b1;
    I_CURRENT_LIMIT <= 1'b1;
    @(posedge I_CLK);
    I_ADJUST_DONE <= 1'b0;
    I_ADJUST_CODE <= 4'h3;
    rc(7'h6C, 8'h91);
    wr(7'h6C, 8'h00);
    @(posedge I_CLK) I_CURRENT_LIMIT <= 1'b0;
    rc(7'h6C, 8'h90);
    @(posedge I_CLK);
    {I_AMPLITUDE_LEVEL, I_PHASE_LEVEL, I_RX_START} <= {8'h37, 1'b1};
    @(posedge I_CLK);
    {I_AMPLITUDE_LEVEL, I_PHASE_LEVEL, I_RX_START} <= {8'hA2, 1'b0};
    @(posedge I_CLK);
    {I_AMPLITUDE_LEVEL, I_PHASE_LEVEL} <= 8'h11;
    wr(7'h2D, 8'h00);
    rc(7'h2D, 8'hA7);
    @(posedge I_CLK) I_CLEAR_RSSI <= 1'b1;
    @(posedge I_CLK) I_CLEAR_RSSI <= 1'b0;
    rc(7'h2D, 8'h11);
    @(posedge I_CLK);
    {I_AMPLITUDE_LEVEL, I_PHASE_LEVEL, I_RX_START} <= {8'h42, 1'b1};
    @(posedge I_CLK) I_RX_START <= 1'b0;
    rc(7'h2D, 8'h42);
    foreach (AUXP[i]) begin
      @(posedge I_CLK) aux_in <= AUXP[i];
      rc(7'h31, {AUXP[i][8:7], AUXP[i][6] & ~AUXP[i][5], AUXP[i][4:0]});
    end
    foreach (WCFG[i]) begin
      wr(7'h32, WCFG[i]);
      wait_tmo(n);
      chk("measure", {O_MEASURE_AMPLITUDE, O_MEASURE_PHASE}, WCFG[i][2:1]);
      wait_tmo(n);
      chk("period", n, (WCFG[i][6:4] + 1) * (WCFG[i][7] ? SHORT : LONG));
    end
    // a difference equal to the delta must stay quiet
    @(posedge I_CLK);
    I_AMPLITUDE_DELTA <= 4'h4;
    I_PHASE_DELTA <= 4'h4;
    meas(8'h50, 8'h33, 2'b10);
    meas(8'h44, 8'h10, 2'b01);
    @(posedge I_CLK) I_RST <= 1'b1;
    repeat (2) @(posedge I_CLK);
    I_RST <= 1'b0;
    rc(7'h70, 8'h00);
    rc(7'h72, 8'h00);
    rc(7'h32, 8'h00);
    chk("cells reset", {O_OVERSHOOT_CELLS, O_UNDERSHOOT_DRIVE_LEVEL}, 16'h0000);
    give_verdict();
  end
endmodule // tb_rsawr_regs
bind rsawr_regs rsawr_regs_monitor #(.BASE_LONG_CYC(BASE_LONG_CYC),
  .BASE_SHORT_CYC(BASE_SHORT_CYC)) mon_u (.I_CLK, .I_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
  .O_RDATA, .I_CURRENT_LIMIT, .I_AMPLITUDE_GAIN_CUT, .I_PHASE_GAIN_CUT, .I_RX_CHANNEL_PM,
  .I_FIELD_DETECTED, .I_TX_ACTIVE, .I_TX_AUTO_AVOID, .I_OSC_STABLE, .I_RX_ENABLED,
  .I_RX_RECEIVING, .I_PEER_DETECT, .I_COLLISION_AVOID_ACTIVE, .I_MEAS_DONE,
  .O_REGULATOR_CONTINUOUS, .O_RX_ONLY_SUPPLY, .O_TXONOFF_SHAPING, .O_SHAPE_SYMMETRY,
  .O_STRONG_SINK, .O_REFERENCE_FILTER_CONSTANT, .O_UNDERSHOOT_CELLS, .O_OVERSHOOT_DRIVE_LEVEL,
  .O_UNDERSHOOT_DRIVE_LEVEL, .O_OVERSHOOT_AM_MASK_VALID, .O_IRQ_TIMEOUT, .O_IRQ_AMPLITUDE_WAKE,
  .O_IRQ_PHASE_WAKE);
